/* bench/km_sink_model.sv */
`timescale 1ns/10ps

module km_sink_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // pacing set by the bench
  input wire logic stall,
  input wire logic slow,
  // stream from the switch
  input wire logic km_out_valid,
  input wire psd_pkg::km_word_s km_out,
  output logic km_out_ready
);
  psd_pkg::km_word_s got[$];
  logic phase = 1'b0;
  logic rdy = 1'b0;

  // ****************************************************************
  // consumer pacing, changed only just after a rising edge
  // ****************************************************************
  assign km_out_ready = rdy;

  always @(posedge sys_clk) begin
    if (reset) begin
      phase <= 1'b0;
      rdy <= 1'b0;
    end else begin
      phase <= ~phase;
      rdy <= !stall && !(slow && !phase);
    end
  end

  // ****************************************************************
  // words taken by the selected computer
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (!reset && km_out_valid === 1'b1 && rdy === 1'b1) begin
      got.push_back(km_out);
    end
  end

endmodule : km_sink_model

/* bench/tb_top.sv */
`timescale 1ns/10ps

module tb_top;

  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int UA_OFF = 20;
  localparam int W = psd_pkg::NUM_CH;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [W-1:0] select_button = '0;
  logic [W-1:0] remote_button = '0;
  logic self_test_done = 1'b1;
  logic self_test_fail = 1'b0;
  logic km_in_valid = 1'b0;
  psd_pkg::km_word_s km_in = '0;
  logic km_in_ready, km_out_valid, km_out_ready, km_emulate;
  psd_pkg::km_word_s km_out;
  logic [W-1:0] km_out_channel, ua_channel, selected_led, osd_marker;
  logic enum_valid = 1'b0;
  logic [7:0] enum_class = 8'h00;
  logic enum_authorized = 1'b0;
  logic audio_dev_present = 1'b0;
  logic audio_dev_authorized = 1'b0;
  logic auth_element_present = 1'b1;
  logic auth_device_attached = 1'b1;
  logic session_start = 1'b0;
  logic video_in_is_dp = 1'b0;
  logic video_out_is_dp = 1'b0;
  logic admin_authenticated = 1'b0;
  logic factory_restore_req = 1'b0;
  logic periph_reject, audio_power, session_open, ua_power;
  psd_pkg::video_gate_s video_gate;
  logic video_to_hdmi, video_out_dp, edid_read_start;
  logic fail_led, fail_buzzer, config_wipe, admin_reject;
  logic stall = 1'b1;
  logic slow = 1'b0;
  psd_pkg::km_word_s sent[$];
  int num_errors = 0;
  int tests_run = 0;
  int edid_cnt = 0;
  int low_run = 0;
  int last_low = 0;
  int ind_bad = 0;

  always #12.5 sys_clk = ~sys_clk;

  secure_peripheral_switch_ctrl #(.UA_OFF_CYCLES(UA_OFF)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .select_button(select_button),
    .remote_button(remote_button), .self_test_done(self_test_done),
    .self_test_fail(self_test_fail), .km_in_valid(km_in_valid),
    .km_in(km_in), .km_in_ready(km_in_ready),
    .km_out_valid(km_out_valid), .km_out(km_out),
    .km_out_ready(km_out_ready), .km_out_channel(km_out_channel),
    .km_emulate(km_emulate), .enum_valid(enum_valid),
    .enum_class(enum_class), .enum_authorized(enum_authorized),
    .periph_reject(periph_reject), .audio_dev_present(audio_dev_present),
    .audio_dev_authorized(audio_dev_authorized),
    .audio_power(audio_power), .auth_element_present(auth_element_present),
    .auth_device_attached(auth_device_attached),
    .session_start(session_start), .session_open(session_open),
    .ua_power(ua_power), .ua_channel(ua_channel),
    .video_in_is_dp(video_in_is_dp), .video_out_is_dp(video_out_is_dp),
    .video_gate(video_gate), .video_to_hdmi(video_to_hdmi),
    .video_out_dp(video_out_dp), .edid_read_start(edid_read_start),
    .selected_led(selected_led), .osd_marker(osd_marker),
    .fail_led(fail_led), .fail_buzzer(fail_buzzer),
    .admin_authenticated(admin_authenticated),
    .factory_restore_req(factory_restore_req),
    .config_wipe(config_wipe), .admin_reject(admin_reject)
  );

  km_sink_model snk_u (
    .sys_clk(sys_clk), .reset(reset), .stall(stall), .slow(slow),
    .km_out_valid(km_out_valid), .km_out(km_out),
    .km_out_ready(km_out_ready)
  );

  // ****************************************************************
  // monitors: display reads, power-off spans, indicator agreement
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (reset) begin
      edid_cnt <= 0;
      low_run <= 0;
    end else begin
      if (edid_read_start === 1'b1) begin
        edid_cnt <= edid_cnt + 1;
      end
      if (ua_power === 1'b0) begin
        low_run <= low_run + 1;
      end else begin
        if (low_run > 0) begin
          last_low <= low_run;
        end
        low_run <= 0;
      end
    end
  end

  always @(negedge sys_clk) begin
    if (!reset && (osd_marker !== selected_led ||
        km_out_channel !== selected_led || ua_channel !== selected_led)) begin
      ind_bad++;
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic do_reset;
    reset = 1'b1;
    cyc(10);
    reset = 1'b0;
    cyc(4);
  endtask : do_reset

  task automatic press(input logic [W-1:0] ch, input logic remote);
    if (remote) begin
      remote_button = ch;
    end else begin
      select_button = ch;
    end
    cyc(4);
    select_button = '0;
    remote_button = '0;
    cyc(4);
  endtask : press

  task automatic pulse_session;
    session_start = 1'b1;
    cyc(1);
    session_start = 1'b0;
    cyc(2);
  endtask : pulse_session

  task automatic enum_pulse(input logic [7:0] cls, input logic auth);
    enum_class = cls;
    enum_authorized = auth;
    enum_valid = 1'b1;
    cyc(1);
    enum_valid = 1'b0;
    cyc(2);
  endtask : enum_pulse

  task automatic admin_req(input logic auth, output int wipe, output int rej);
    wipe = 0;
    rej = 0;
    admin_authenticated = auth;
    factory_restore_req = 1'b1;
    cyc(1);
    factory_restore_req = 1'b0;
    repeat (4) begin
      wipe += int'(config_wipe === 1'b1);
      rej += int'(admin_reject === 1'b1);
      cyc(1);
    end
  endtask : admin_req

  // stops at the first refusal and drops valid; words are offered only while ready is high
  task automatic push_words(input int max, output int n);
    n = 0;
    while (n < max && km_in_ready === 1'b1) begin
      km_in_valid = 1'b1;
      km_in = {n[0], 8'ha0 + 8'(n)};
      sent.push_back(km_in);
      n++;
      cyc(1);
    end
    km_in_valid = 1'b0;
  endtask : push_words

  task automatic wait_ua;
    int i;
    i = 0;
    while (ua_power !== 1'b1 && i < 100) begin
      cyc(1);
      i++;
    end
    // let the power-off monitor record the finished span
    cyc(1);
  endtask : wait_ua

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_state;
    check(km_emulate, 1'b1);
    check(selected_led, 4'h1);
    check(osd_marker, 4'h1);
    check(km_out_channel, 4'h1);
    cyc(30);
    check(edid_cnt, 1);
  endtask : t_reset_state

  task automatic t_video;
    video_in_is_dp = 1'b1;
    video_out_is_dp = 1'b1;
    cyc(3);
    check(video_gate, 10'h380);
    check(video_to_hdmi, 1'b1);
    check(video_out_dp, 1'b1);
    video_in_is_dp = 1'b0;
    video_out_is_dp = 1'b0;
    cyc(3);
    check(video_gate, 10'h300);
    check(video_to_hdmi, 1'b0);
    check(video_out_dp, 1'b0);
  endtask : t_video

  task automatic t_audio_enum;
    audio_dev_present = 1'b1;
    cyc(2);
    check(audio_power, 1'b0);
    audio_dev_authorized = 1'b1;
    cyc(2);
    check(audio_power, 1'b1);
    audio_dev_present = 1'b0;
    cyc(2);
    check(audio_power, 1'b0);
    enum_pulse(8'h03, 1'b1);
    check(periph_reject, 1'b0);
    enum_pulse(8'h08, 1'b0);
    check(periph_reject, 1'b1);
    enum_pulse(8'h03, 1'b1);
    check(periph_reject, 1'b0);
  endtask : t_audio_enum

  task automatic t_admin;
    int wipe;
    int rej;
    admin_req(1'b0, wipe, rej);
    check(wipe, 0);
    check(rej, 1);
    admin_req(1'b1, wipe, rej);
    check(wipe, 1);
    check(rej, 0);
  endtask : t_admin

  task automatic t_km_fill;
    int n;
    int i;
    sent.delete();
    snk_u.got.delete();
    push_words(20, n);
    check(km_in_ready, 1'b0);
    check(n >= psd_pkg::KM_FIFO_DEPTH, 1'b1);
    stall = 1'b0;
    slow = 1'b1;
    i = 0;
    while (snk_u.got.size() < n && i < 200) begin
      cyc(1);
      i++;
    end
    check(snk_u.got.size(), n);
    foreach (sent[k]) check(snk_u.got[k], sent[k]);
    slow = 1'b0;
  endtask : t_km_fill

  task automatic t_switch;
    int n;
    pulse_session();
    check(session_open, 1'b1);
    stall = 1'b1;
    snk_u.got.delete();
    push_words(3, n);
    cyc(3);
    press(4'h4, 1'b0);
    check(selected_led, 4'h4);
    check(session_open, 1'b0);
    check(ua_power, 1'b0);
    press(4'h8, 1'b1);
    check(selected_led, 4'h4);
    wait_ua();
    check(last_low >= UA_OFF, 1'b1);
    stall = 1'b0;
    cyc(10);
    check(snk_u.got.size(), 0);
    press(4'h3, 1'b0);
    check(selected_led, 4'h4);
    press(4'h8, 1'b1);
    check(selected_led, 4'h8);
    wait_ua();
  endtask : t_switch

  task automatic t_session;
    pulse_session();
    check(session_open, 1'b1);
    auth_element_present = 1'b0;
    cyc(6);
    check(session_open, 1'b0);
    auth_element_present = 1'b1;
    cyc(4);
    pulse_session();
    check(session_open, 1'b1);
    auth_device_attached = 1'b0;
    cyc(6);
    check(session_open, 1'b0);
    auth_device_attached = 1'b1;
    cyc(4);
  endtask : t_session

  task automatic t_fail;
    self_test_done = 1'b0;
    self_test_fail = 1'b1;
    do_reset();
    check(fail_led, 1'b1);
    check(fail_buzzer, 1'b1);
    check(video_gate, 10'h000);
    press(4'h2, 1'b0);
    check(selected_led, 4'h1);
    check(fail_led, 1'b1);
    check(edid_cnt, 0);
    self_test_fail = 1'b0;
    self_test_done = 1'b1;
    do_reset();
    check(fail_led, 1'b0);
  endtask : t_fail

  // ****************************************************************
  // verdict and run control
  // ****************************************************************
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(25 * 5000);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    do_reset();
    t_reset_state();
    t_video();
    t_audio_enum();
    t_admin();
    t_km_fill();
    t_switch();
    t_session();
    check(ind_bad, 0);
    t_fail();
    finish_test();
  end

endmodule : tb_top

/* core/psd_pkg.sv */
package psd_pkg;

  // ****************************************************************
  // channel and stream shape
  // ****************************************************************
  localparam int NUM_CH = 4;
  localparam int KM_DATA_W = 8;
  localparam int KM_FIFO_DEPTH = 8;
  localparam logic [NUM_CH-1:0] CH_AT_RESET = 4'h1;
  localparam logic [NUM_CH-1:0] CH_NONE = 4'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int UA_OFF_MS = 1000;
  localparam int UA_OFF_CYCLES = UA_OFF_MS * (CLK_HZ / 1000);
  localparam int UA_CNT_W = 26;

  // ****************************************************************
  // peripheral enumeration
  // ****************************************************************
  localparam logic [7:0] CLASS_NONE = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_TEST = 5'h01,
    ST_RUN = 5'h02,
    ST_PURGE = 5'h04,
    ST_UA_OFF = 5'h08,
    ST_FAIL = 5'h10
  } sw_state_e;

  typedef struct packed {
    logic is_mouse;
    logic [KM_DATA_W-1:0] data;
  } km_word_s;

  // one bit per video sub-protocol, high lets it pass
  typedef struct packed {
    logic edid_d2c;
    logic hpd_d2c;
    logic link_train;
    logic edid_c2d;
    logic cec;
    logic hdcp;
    logic mccs;
    logic arc;
    logic heac;
    logic hec;
  } video_gate_s;

  localparam video_gate_s GATE_DP = 10'h380;
  localparam video_gate_s GATE_HDMI = 10'h300;
  localparam video_gate_s GATE_NONE = 10'h000;

endpackage : psd_pkg

/* core/secure_peripheral_switch_ctrl.sv */
`timescale 1ns/10ps

// ******************************************************************
// keyboard data fifo
// ******************************************************************
module km_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != FULL);
    end
  end
endmodule : km_fifo

// Summary of operation
// - present emulated keyboard and mouse functions
// - read display identification once after reset
// - no power to unauthorized audio device
// - reject re-enumeration as unauthorized type
// - never store user traffic in non-volatile memory
// - purge buffered keyboard data on every switch
// - admin factory restore keeps the log
// - displayport passes only edid, hpd, training
// - hdmi passes only display edid and hpd
// - switch only on express user button action
// - keyboard and mouse always switch together
// - end session when auth element removed
// - end session when auth device detached
// - end session on every computer switch
// - auth device unpowered one second on switch
// - auth path separate from other usb paths
// - every data path flows one way only
// - refuse admin actions until admin authenticated
// - self-test failure gives light, sound, shutdown
// - selection always shown by buttons and screen
// - all indicators driven from one state
// - displayport input converted internally to hdmi
module secure_peripheral_switch_ctrl #(
  parameter int UA_OFF_CYCLES = psd_pkg::UA_OFF_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // user selection pins
  input wire logic [psd_pkg::NUM_CH-1:0] select_button,
  input wire logic [psd_pkg::NUM_CH-1:0] remote_button,
  // self-test
  input wire logic self_test_done,
  input wire logic self_test_fail,
  // keyboard and mouse stream from peripherals
  input wire logic km_in_valid,
  input wire psd_pkg::km_word_s km_in,
  output logic km_in_ready,
  // keyboard and mouse stream toward selected computer
  output logic km_out_valid,
  output psd_pkg::km_word_s km_out,
  input wire logic km_out_ready,
  output logic [psd_pkg::NUM_CH-1:0] km_out_channel,
  output logic km_emulate,
  // peripheral enumeration
  input wire logic enum_valid,
  input wire logic [7:0] enum_class,
  input wire logic enum_authorized,
  output logic periph_reject,
  // analog audio
  input wire logic audio_dev_present,
  input wire logic audio_dev_authorized,
  output logic audio_power,
  // user authentication device
  input wire logic auth_element_present,
  input wire logic auth_device_attached,
  input wire logic session_start,
  output logic session_open,
  output logic ua_power,
  output logic [psd_pkg::NUM_CH-1:0] ua_channel,
  // video
  input wire logic video_in_is_dp,
  input wire logic video_out_is_dp,
  output psd_pkg::video_gate_s video_gate,
  output logic video_to_hdmi,
  output logic video_out_dp,
  output logic edid_read_start,
  // indicators
  output logic [psd_pkg::NUM_CH-1:0] selected_led,
  output logic [psd_pkg::NUM_CH-1:0] osd_marker,
  output logic fail_led,
  output logic fail_buzzer,
  // administration
  input wire logic admin_authenticated,
  input wire logic factory_restore_req,
  output logic config_wipe,
  output logic admin_reject
);

  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int PIN_W = 2 * psd_pkg::NUM_CH + 2;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [2*psd_pkg::NUM_CH-1:0] btn_prev;
  logic [psd_pkg::NUM_CH-1:0] press;
  logic auth_elem_s;
  logic auth_dev_s;
  logic user_req;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      btn_prev <= '0;
    end else begin
      pin_s1 <= {auth_device_attached, auth_element_present,
                 remote_button, select_button};
      pin_s2 <= pin_s1;
      btn_prev <= pin_s2[2*psd_pkg::NUM_CH-1:0];
    end
  end

  assign auth_elem_s = pin_s2[2*psd_pkg::NUM_CH];
  assign auth_dev_s = pin_s2[2*psd_pkg::NUM_CH+1];
  // new press on front panel or wired remote only
  assign press = (pin_s2[psd_pkg::NUM_CH-1:0] & ~btn_prev[psd_pkg::NUM_CH-1:0])
    | (pin_s2[2*psd_pkg::NUM_CH-1:psd_pkg::NUM_CH]
       & ~btn_prev[2*psd_pkg::NUM_CH-1:psd_pkg::NUM_CH]);

  // ****************************************************************
  // switching state machine
  // ****************************************************************
  psd_pkg::sw_state_e state;
  psd_pkg::sw_state_e next_state;
  logic [psd_pkg::NUM_CH-1:0] sel;
  logic [psd_pkg::UA_CNT_W-1:0] ua_cnt;
  logic ua_done;

  assign ua_done = (ua_cnt == psd_pkg::UA_CNT_W'(UA_OFF_CYCLES - 1));
  assign user_req = $onehot(press) && (press != sel);

  always_comb begin
    next_state = state;
    unique case (state)
      psd_pkg::ST_TEST: begin
        if (self_test_fail) begin
          next_state = psd_pkg::ST_FAIL;
        end else if (self_test_done) begin
          next_state = psd_pkg::ST_RUN;
        end
      end
      psd_pkg::ST_RUN: begin
        if (user_req) begin
          next_state = psd_pkg::ST_PURGE;
        end
      end
      psd_pkg::ST_PURGE: next_state = psd_pkg::ST_UA_OFF;
      psd_pkg::ST_UA_OFF: begin
        if (ua_done) begin
          next_state = psd_pkg::ST_RUN;
        end
      end
      psd_pkg::ST_FAIL: next_state = psd_pkg::ST_FAIL;
      default: next_state = psd_pkg::ST_FAIL;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= psd_pkg::ST_TEST;
    end else begin
      state <= next_state;
    end
  end

  // one register selects keyboard, mouse, auth and indicators
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sel <= psd_pkg::CH_AT_RESET;
    end else if (state == psd_pkg::ST_RUN && user_req) begin
      sel <= press;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || state != psd_pkg::ST_UA_OFF) begin
      ua_cnt <= '0;
    end else if (!ua_done) begin
      ua_cnt <= ua_cnt + 1'b1;
    end
  end

  // ****************************************************************
  // keyboard and mouse path
  // ****************************************************************
  logic fifo_valid;
  psd_pkg::km_word_s fifo_data;
  logic fifo_take;
  logic purge;

  assign purge = (state == psd_pkg::ST_PURGE);
  assign fifo_take = (state == psd_pkg::ST_RUN)
    && (!km_out_valid || km_out_ready);

  // volatile registers only, cleared on purge
  km_fifo #(
    .WIDTH($bits(psd_pkg::km_word_s)),
    .DEPTH(psd_pkg::KM_FIFO_DEPTH)
  ) u_km_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .flush(purge),
    .in_valid(km_in_valid),
    .in_data(km_in),
    .in_ready(km_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_take)
  );

  // peripheral to computer only, no reverse data path
  always_ff @(posedge sys_clk) begin
    if (reset || purge) begin
      km_out_valid <= 1'b0;
      km_out <= '0;
    end else if (state != psd_pkg::ST_RUN) begin
      km_out_valid <= km_out_valid && !km_out_ready;
    end else if (fifo_take) begin
      km_out_valid <= fifo_valid;
      km_out <= fifo_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      km_out_channel <= psd_pkg::CH_AT_RESET;
      selected_led <= psd_pkg::CH_AT_RESET;
      osd_marker <= psd_pkg::CH_AT_RESET;
      ua_channel <= psd_pkg::CH_AT_RESET;
      km_emulate <= 1'b1;
    end else begin
      km_out_channel <= sel;
      selected_led <= sel;
      osd_marker <= sel;
      ua_channel <= sel;
      km_emulate <= 1'b1;
    end
  end

  // ****************************************************************
  // enumeration and audio power
  // ****************************************************************
  logic [7:0] accepted_class;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      accepted_class <= psd_pkg::CLASS_NONE;
      periph_reject <= 1'b0;
    end else if (enum_valid) begin
      if (enum_authorized) begin
        accepted_class <= enum_class;
        periph_reject <= 1'b0;
      end else begin
        periph_reject <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      audio_power <= 1'b0;
    end else begin
      audio_power <= audio_dev_present && audio_dev_authorized;
    end
  end

  // ****************************************************************
  // authentication session and power
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      session_open <= 1'b0;
    end else if (!auth_elem_s || !auth_dev_s || purge
                 || state == psd_pkg::ST_UA_OFF) begin
      session_open <= 1'b0;
    end else if (session_start) begin
      session_open <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ua_power <= 1'b0;
    end else begin
      ua_power <= (next_state == psd_pkg::ST_RUN);
    end
  end

  // ****************************************************************
  // video
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      video_gate <= psd_pkg::GATE_NONE;
      video_to_hdmi <= 1'b0;
      video_out_dp <= 1'b0;
      edid_read_start <= 1'b0;
    end else begin
      if (state != psd_pkg::ST_RUN) begin
        video_gate <= psd_pkg::GATE_NONE;
      end else if (video_in_is_dp) begin
        video_gate <= psd_pkg::GATE_DP;
      end else begin
        video_gate <= psd_pkg::GATE_HDMI;
      end
      video_to_hdmi <= video_in_is_dp;
      video_out_dp <= video_out_is_dp;
      edid_read_start <= (state == psd_pkg::ST_TEST)
        && (next_state == psd_pkg::ST_RUN);
    end
  end

  // ****************************************************************
  // failure and administration
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fail_led <= 1'b0;
      fail_buzzer <= 1'b0;
    end else begin
      fail_led <= (next_state == psd_pkg::ST_FAIL);
      fail_buzzer <= (next_state == psd_pkg::ST_FAIL);
    end
  end

  // wipe strobe clears settings; the log store is not on it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      config_wipe <= 1'b0;
      admin_reject <= 1'b0;
    end else begin
      config_wipe <= factory_restore_req && admin_authenticated;
      admin_reject <= factory_restore_req && !admin_authenticated;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [1:0] edid_count;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      edid_count <= '0;
    end else if (edid_read_start && edid_count != 2'h3) begin
      edid_count <= edid_count + 1'b1;
    end
  end

  sequence seq_switch_start;
    state == psd_pkg::ST_RUN && user_req;
  endsequence

  sequence seq_purged;
    state == psd_pkg::ST_PURGE ##1 !km_out_valid && !fifo_valid;
  endsequence

  a_purge_on_switch: assert property (seq_switch_start |=> seq_purged)
    else $error("keyboard data not purged on switch");

  a_km_tied_sel: assert property (km_out_channel == ua_channel
    && km_out_channel == selected_led)
    else $error("keyboard, mouse and auth channel differ");

  a_ind_consistent: assert property (selected_led == osd_marker
    && $onehot(selected_led))
    else $error("indicators show conflicting selection");

  a_switch_cause: assert property ($changed(sel)
    |-> $past(user_req) && $past(state == psd_pkg::ST_RUN))
    else $error("selection changed without user press");

  a_fail_latched: assert property (fail_led |=> fail_led
    && fail_buzzer && $stable(sel) && !ua_power)
    else $error("failure state left or selection moved");

  a_fail_shutdown: assert property (state == psd_pkg::ST_TEST
    && self_test_fail |=> fail_led
    ##1 video_gate == psd_pkg::GATE_NONE && !km_out_valid)
    else $error("self-test failure did not shut down");

  a_edid_once_only: assert property (edid_count <= 2'h1)
    else $error("display identification read more than once");

  a_session_switch: assert property (seq_switch_start
    |-> ##2 !session_open [*3])
    else $error("session open after switch");

  a_session_removal: assert property (!auth_elem_s || !auth_dev_s
    |=> !session_open)
    else $error("session open after auth removal");

  a_ua_off_time: assert property (state == psd_pkg::ST_UA_OFF
    && next_state == psd_pkg::ST_RUN
    |-> ua_cnt == psd_pkg::UA_CNT_W'(UA_OFF_CYCLES - 1) && !ua_power)
    else $error("auth device power restored too early");

  a_audio_power: assert property (!audio_dev_authorized
    |=> !audio_power)
    else $error("unauthorized audio device powered");

  a_admin_refuse: assert property (factory_restore_req
    && !admin_authenticated |=> admin_reject && !config_wipe)
    else $error("admin action taken without authentication");

endmodule : secure_peripheral_switch_ctrl
